// file: rtl/irg_gate.sv
// Interrupt request gating: factor flags, masks, global accept, SP guard
// How it works
// - Factor flags set on their source event whatever the mask bit holds.
// - A set flag requests again once acceptance returns or return executes.
// - After reset every interrupt, NMI too, waits for both pointer writes.
// - Writing one pointer blocks all interrupts until the other is written.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module irg_gate
  import irg_pkg::*;
(
  input wire logic clock, // System clock, 20 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic hsel, // AHB-Lite slave select
  input wire logic [31:0] haddr, // AHB-Lite address
  input wire logic [1:0] htrans, // AHB-Lite transfer type
  input wire logic hwrite, // AHB-Lite write
  input wire logic [2:0] hsize, // AHB-Lite size
  input wire logic [31:0] hwdata, // AHB-Lite write data
  input wire logic hready, // AHB-Lite bus ready
  output logic [31:0] hrdata, // AHB-Lite read data
  output logic hreadyout, // AHB-Lite slave ready
  output logic [1:0] hresp, // AHB-Lite response
  input wire logic [IRG_NSRC-1:0] src_event, // Source condition pulses
  input wire logic nmi_event, // Non-maskable source pulse
  input wire logic accept_set, // CPU sets global acceptance
  input wire logic accept_clr, // CPU clears acceptance (entry)
  input wire logic return_from_interrupt, // Return executed, restores
  output logic [IRG_NSRC-1:0] irq_req, // Maskable requests to the CPU
  output logic nmi_req, // Non-maskable request to the CPU
  output logic [IRG_SPW-1:0] stack_pointer_one, // Stack pointer one
  output logic [IRG_SPW-1:0] stack_pointer_two // Stack pointer two
);
  import irg_pkg::*;

  logic [IRG_NSRC-1:0] flag;
  logic [IRG_NSRC-1:0] mask;
  logic accept;
  logic nmi_pend;
  logic dp_write;
  logic [31:0] dp_addr;
  logic sp1_done;
  logic sp2_done;
  logic open_gate;

  // Address phase capture
  wire logic addr_ok = hsel & hready & htrans[1];
  wire logic wr_strobe = dp_write & ce;
  wire logic wr_flag = wr_strobe & (dp_addr == IRG_FLAG_ADDR);
  wire logic wr_mask = wr_strobe & (dp_addr == IRG_MASK_ADDR);
  wire logic wr_ctrl = wr_strobe & (dp_addr == IRG_CTRL_ADDR);
  wire logic wr_sp1 = wr_strobe & (dp_addr == IRG_SP1_ADDR);
  wire logic wr_sp2 = wr_strobe & (dp_addr == IRG_SP2_ADDR);
  wire logic [IRG_NSRC-1:0] clr_bits = wr_flag ? hwdata[IRG_NSRC-1:0]
                                                : '0;
  wire logic [IRG_NSRC-1:0] next_flag;
  wire logic [IRG_NSRC-1:0] next_irq;

  // Write data fields, valid in the data phase
  wire logic [IRG_NSRC-1:0] wr_mask_val = hwdata[IRG_NSRC-1:0];
  wire logic [IRG_SPW-1:0] wr_sp_val = hwdata[IRG_SPW-1:0];
  wire logic wr_ie_val = hwdata[IRG_CTRL_IE_BIT];

  // Acceptance: CPU pulses, then a control write overrides them
  wire logic accept_pulse = accept_set | return_from_interrupt;
  wire logic accept_keep = accept & ~accept_clr;
  wire logic next_accept_run = accept_pulse | accept_keep;
  wire logic next_accept = wr_ctrl ? wr_ie_val : next_accept_run;

  // The non-maskable source waits for the pointer gate like the rest
  wire logic nmi_taken = open_gate & nmi_req;
  wire logic next_nmi_pend = nmi_event | (nmi_pend & ~nmi_taken);
  wire logic next_nmi_req = open_gate & nmi_pend & ~nmi_req;

  // Read side decode, taken from the address phase
  wire logic rd_flag = (haddr == IRG_FLAG_ADDR);
  wire logic rd_mask = (haddr == IRG_MASK_ADDR);
  wire logic rd_ctrl = (haddr == IRG_CTRL_ADDR);
  wire logic rd_sp1 = (haddr == IRG_SP1_ADDR);
  wire logic rd_sp2 = (haddr == IRG_SP2_ADDR);
  wire logic rd_stat = (haddr == IRG_STAT_ADDR);
  wire logic rd_go = addr_ok & ~hwrite;
  wire logic [31:0] stat_word = {29'h0, open_gate, sp2_done, sp1_done};
  wire logic [31:0] rd_mux =
    rd_flag ? {28'h0, flag} :
    rd_mask ? {28'h0, mask} :
    rd_ctrl ? {31'h0, accept} :
    rd_sp1 ? {24'h0, stack_pointer_one} :
    rd_sp2 ? {24'h0, stack_pointer_two} :
    rd_stat ? stat_word : 32'h0;

  irg_sp_guard u_guard (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .wr_sp1(wr_sp1),
    .wr_sp2(wr_sp2),
    .sp1_done(sp1_done),
    .sp2_done(sp2_done),
    .open_gate(open_gate)
  );

  // Write data phase: remember the accepted address and direction
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dp_write <= 1'b0;
      dp_addr <= 32'h0;
    end
    else if (ce)
    begin
      dp_write <= addr_ok & hwrite;
      dp_addr <= haddr;
    end
  end

  // Read data stands for the one data phase cycle, zero otherwise
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hrdata <= 32'h0;
    end
    else if (ce)
    begin
      hrdata <= rd_go ? rd_mux : 32'h0;
    end
  end

  // Zero wait and always OKAY, still taken from flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hreadyout <= 1'b1;
      hresp <= IRG_HRESP_OKAY;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= IRG_HRESP_OKAY;
    end
  end

  // Per source: factor flag and its gated request
  for (genvar i = 0; i < IRG_NSRC; i++)
  begin : g_src
    // Set wins when an event meets a write-one clear in one cycle
    assign next_flag[i] = src_event[i] | (flag[i] & ~clr_bits[i]);
    // Mask bit, acceptance and the pointer gate are all needed
    assign next_irq[i] = open_gate & next_flag[i] & mask[i] &
                         next_accept;

    always_ff @(posedge clock or negedge nrst)
    begin
      if (!nrst)
      begin
        flag[i] <= 1'b0;
        irq_req[i] <= 1'b0;
      end
      else if (ce)
      begin
        flag[i] <= next_flag[i];
        irq_req[i] <= next_irq[i];
      end
    end
  end : g_src

  // Mask and global acceptance
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mask <= IRG_MASK_RST;
      accept <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_mask)
        mask <= wr_mask_val;
      accept <= next_accept;
    end
  end

  // Pointer values; the guard tracks which half of the pair is in
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stack_pointer_one <= IRG_SP_RST;
      stack_pointer_two <= IRG_SP_RST;
    end
    else if (ce)
    begin
      if (wr_sp1)
        stack_pointer_one <= wr_sp_val;
      if (wr_sp2)
        stack_pointer_two <= wr_sp_val;
    end
  end

  // NMI held pending until the pair is written, events pending together give one pulse
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      nmi_pend <= 1'b0;
      nmi_req <= 1'b0;
    end
    else if (ce)
    begin
      nmi_pend <= next_nmi_pend;
      nmi_req <= next_nmi_req;
    end
  end
endmodule // irg_gate

// file: rtl/irg_pkg.sv
// Package: register map and constants for the interrupt request gating block
package irg_pkg;
  localparam int IRG_NSRC = 4;
  localparam int IRG_SPW = 8;
  localparam logic [31:0] IRG_FLAG_ADDR = 32'h0000_0000;
  localparam logic [31:0] IRG_MASK_ADDR = 32'h0000_0004;
  localparam logic [31:0] IRG_CTRL_ADDR = 32'h0000_0008;
  localparam logic [31:0] IRG_SP1_ADDR = 32'h0000_000c;
  localparam logic [31:0] IRG_SP2_ADDR = 32'h0000_0010;
  localparam logic [31:0] IRG_STAT_ADDR = 32'h0000_0014;
  localparam logic [3:0] IRG_MASK_RST = 4'h0;
  localparam logic [7:0] IRG_SP_RST = 8'h00;
  localparam int IRG_CTRL_IE_BIT = 0;
  localparam int IRG_STAT_SP1_BIT = 0;
  localparam int IRG_STAT_SP2_BIT = 1;
  localparam int IRG_STAT_OPEN_BIT = 2;
  localparam logic [1:0] IRG_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] IRG_HTRANS_SEQ = 2'h3;
  localparam logic [1:0] IRG_HRESP_OKAY = 2'h0;
  typedef enum logic [1:0] {IRG_ARM_NONE, IRG_ARM_ONE, IRG_ARM_TWO,
    IRG_ARM_OPEN} irg_arm_t;
endpackage

// file: rtl/irg_sp_guard.sv
// Stack pointer pairing guard that holds off every interrupt
`timescale 1ns/10ps
module irg_sp_guard
  import irg_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic wr_sp1, // Stack pointer one written
  input wire logic wr_sp2, // Stack pointer two written
  output logic sp1_done, // Pointer one written in this pair
  output logic sp2_done, // Pointer two written in this pair
  output logic open_gate // Interrupts may pass
);
  logic next_sp1_done;
  logic next_sp2_done;
  wire logic pair_full = next_sp1_done & next_sp2_done;

  // A lone write after a full pair starts a new pair; once both are in the gate opens
  always_comb
  begin
    next_sp1_done = sp1_done;
    next_sp2_done = sp2_done;
    if (sp1_done & sp2_done & (wr_sp1 ^ wr_sp2))
    begin
      next_sp1_done = wr_sp1;
      next_sp2_done = wr_sp2;
    end
    else
    begin
      next_sp1_done = sp1_done | wr_sp1;
      next_sp2_done = sp2_done | wr_sp2;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sp1_done <= 1'b0;
      sp2_done <= 1'b0;
      open_gate <= 1'b0;
    end
    else if (ce)
    begin
      sp1_done <= next_sp1_done;
      sp2_done <= next_sp2_done;
      open_gate <= pair_full;
    end
  end
endmodule // irg_sp_guard

// file: dv/irg_props.sv
// Checker for the interrupt request gating block
`timescale 1ns/10ps
module irg_props
  import irg_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic nrst, // Reset
  input wire logic ce, // Enable
  input wire logic hsel, // Select
  input wire logic accept_set, // Accept on
  input wire logic accept_clr, // Accept off
  input wire logic return_from_interrupt, // Return
  input wire logic nmi_event, // NMI source
  input wire logic [IRG_NSRC-1:0] irq_req, // Requests
  input wire logic nmi_req // NMI request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic pend_m;
  // Reference of a latched non-maskable event not yet delivered
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pend_m <= 1'b0;
    else if (ce)
      pend_m <= nmi_event | (pend_m & ~nmi_req);
  end
  AST_RST_BLOCK: assert property ($rose(nrst) |->
    (irq_req == '0 && !nmi_req)[*3]) else $error("request before pointers");
  AST_NMI_ONE: assert property (nmi_req && ce && !nmi_event |=> !nmi_req)
    else $error("nmi request longer than one cycle");
  AST_ACC_OFF: assert property (ce && accept_clr && !accept_set &&
    !return_from_interrupt && !$past(hsel) ##1 ce |=> irq_req == '0)
    else $error("request without acceptance");
  AST_CE_HOLD: assert property (!ce |=>
    $stable(irq_req) && $stable(nmi_req))
    else $error("requests moved while frozen");
  AST_NMI_CAUSE: assert property (ce && !pend_m |=> !nmi_req)
    else $error("nmi request with nothing pending");
endmodule // irg_props

// file: dv/irg_cpu_model.sv
// Model of the CPU core and the peripheral event sources
`timescale 1ns/10ps
module irg_cpu_model
  import irg_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic [IRG_NSRC:0] fire, // Events, top bit NMI
  input wire logic [IRG_NSRC-1:0] irq_req, // Requests
  output logic [IRG_NSRC-1:0] src_event, // Source pulses
  output logic nmi_event, // NMI pulse
  output logic accept_clr // Entry clears acceptance
);
  initial {nmi_event, src_event, accept_clr} = '0;
  always @(posedge clock) {nmi_event, src_event} <= fire;
  // Taking an interrupt drops acceptance for one pulse
  always @(posedge clock) accept_clr <= |irq_req && !accept_clr;
endmodule // irg_cpu_model

// file: dv/irg_gate_bench.sv
// Self-checking bench for the interrupt request gating block
`timescale 1ns/10ps
module irg_gate_bench;
  import irg_pkg::*;
  logic clock = 0, nrst = 0, ce = 1, hsel = 0, hwrite = 0, clr = 0;
  logic accept_set = 0, return_from_interrupt = 0, gotn = 0;
  logic nmi_event, accept_clr, nmi_req, hreadyout;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, hresp;
  logic [3:0] src_event, irq_req, got = 0;
  logic [4:0] fire = 0;
  logic [7:0] sp1, sp2;
  int n_errors = 0, checked = 0, cyc = 0;
  always #25 clock = ~clock;
  irg_gate i_dut (.clock(clock), .nrst(nrst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
    .nmi_event(nmi_event), .accept_set(accept_set), .accept_clr(accept_clr),
    .return_from_interrupt(return_from_interrupt), .irq_req(irq_req),
    .nmi_req(nmi_req), .stack_pointer_one(sp1), .stack_pointer_two(sp2));
  irg_cpu_model i_cpu (.clock(clock), .fire(fire), .irq_req(irq_req),
    .src_event(src_event), .nmi_event(nmi_event), .accept_clr(accept_clr));
  always @(posedge clock) got <= clr ? 4'h0 : got | irq_req;
  always @(posedge clock) gotn <= clr ? 1'b0 : gotn | nmi_req;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      finish_test;
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic [31:0] a, logic [31:0] d, logic w);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= IRG_HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    chk("response", {30'h0, hresp}, {30'h0, IRG_HRESP_OKAY});
  endtask
  task automatic rd(string n, logic [31:0] a, logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    chk(n, hrdata, e);
  endtask
  // Pulses events and CPU controls, then gathers requests for 8 cycles
  task automatic run(logic [4:0] f, logic a, logic r);
    fire <= f;
    accept_set <= a;
    return_from_interrupt <= r;
    clr <= 1;
    @(posedge clock);
    {fire, accept_set, return_from_interrupt, clr} <= '0;
    repeat (8) @(posedge clock);
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1;
    rd("status", IRG_STAT_ADDR, 32'h0);
    rd("mask", IRG_MASK_ADDR, {28'h0, IRG_MASK_RST});
    bus(IRG_MASK_ADDR, 32'he, 1'b1);
    bus(IRG_CTRL_ADDR, 32'h1, 1'b1);
    run(5'h1f, 1'b0, 1'b0);
    chk("irq", {got, gotn}, 5'h0);
    rd("flags", IRG_FLAG_ADDR, 32'hf);
    bus(IRG_SP1_ADDR, 32'h5a, 1'b1);
    run(5'h0, 1'b0, 1'b0);
    chk("irq", {got, gotn}, 5'h0);
    rd("status", IRG_STAT_ADDR, 32'h1);
    bus(IRG_SP2_ADDR, 32'ha5, 1'b1);
    run(5'h0, 1'b0, 1'b0);
    chk("irq", {got, gotn}, 5'h1d);
    chk("pointers", {sp1, sp2}, 16'h5aa5);
    run(5'h0, 1'b0, 1'b1);
    chk("irq", got, 4'he);
    bus(IRG_FLAG_ADDR, 32'h0, 1'b1);
    rd("flags", IRG_FLAG_ADDR, 32'hf);
    bus(IRG_FLAG_ADDR, 32'hf, 1'b1);
    rd("flags", IRG_FLAG_ADDR, 32'h0);
    run(5'h0, 1'b0, 1'b1);
    chk("irq", got, 4'h0);
    bus(IRG_SP1_ADDR, 32'h33, 1'b1);
    run(5'h2, 1'b1, 1'b0);
    chk("irq", got, 4'h0);
    bus(IRG_SP2_ADDR, 32'h44, 1'b1);
    run(5'h0, 1'b0, 1'b0);
    chk("irq", got, 4'h2);
    rd("unmapped", 32'h40, 32'h0);
    ce <= 0;
    repeat (3) @(posedge clock);
    ce <= 1;
    finish_test;
  end
endmodule // irg_gate_bench
bind irg_gate irg_props i_props (.clock(clock), .nrst(nrst), .ce(ce),
  .hsel(hsel), .accept_set(accept_set), .accept_clr(accept_clr),
  .return_from_interrupt(return_from_interrupt), .nmi_event(nmi_event),
  .irq_req(irq_req), .nmi_req(nmi_req));
